// [dsp_cfg.svh]
// Constants of the dual select serial port: register indices, field positions,
// reset values, buffer depth and the layout of the configuration address byte.
// Included by the package; it holds definitions only.
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// Register file and buffer geometry, and the register reset value.
`define DSP_NREG      32
`define DSP_DEPTH     64
`define DSP_PW        6
`define DSP_RST       8'h00

// Configuration address byte: read flag, then a five bit register index.
`define DSP_A_RW      6
`define DSP_A_HI      5
`define DSP_A_LO      1

// Register indices that steer the block, and the status index.
`define DSP_R_GEN     5'h00
`define DSP_R_DMOD    5'h01
`define DSP_R_RATE    5'h03
`define DSP_R_STAT    5'h1F

// Fields: transceiver state, data mode and bit synchronizer enable.
`define DSP_ST_HI     7
`define DSP_ST_LO     5
`define DSP_ST_RX     3'h3
`define DSP_ST_TX     3'h4
`define DSP_MD_HI     3
`define DSP_MD_LO     2
`define DSP_MD_CONT   2'h0
`define DSP_BS_BIT    1

// Last bit index of a byte and the synchroniser idle level of the selects.
`define DSP_BYTE_END  3'h7
`define DSP_SYNC_IDLE 3'h7

`endif

// [dsp_pkg.sv]
// Types of the dual select serial port: link framing, staging, output shifter
// and the core state. Assumes dsp_cfg.svh is on the include path.
`include "dsp_cfg.svh"

package dsp_pkg;

   // Modem shifter states.
   typedef enum logic [1:0] {SH_IDLE, SH_SEND, SH_RECV} dsp_sh_t;

   // Framing state on the serial clock, cleared whenever both selects are high.
   typedef struct packed {
      logic [2:0] cnt;
      logic       val_ph;
      logic       rw;
      logic [4:0] addr;
      logic [6:0] sh;
   } dsp_frame_t;

   // Staged writes and the last data byte, kept across frames.
   typedef struct packed {
      logic [`DSP_NREG-1:0][7:0] stage;
      logic [`DSP_NREG-1:0]      tog;
      logic [7:0]                dbyte;
      logic                      dtog;
   } dsp_store_t;

   // Serial output shifter on the falling serial clock edge.
   typedef struct packed {
      logic       started;
      logic [7:0] tx;
   } dsp_out_t;

   // Core state on the system clock.
   typedef struct packed {
      logic [2:0]                 cfg_q;
      logic [2:0]                 dat_q;
      logic [2:0]                 dtog_q;
      logic [1:0]                 dm_q;
      logic [2:0]                 maj;
      logic [`DSP_NREG-1:0][7:0]  regs;
      logic [`DSP_NREG-1:0]       ack;
      logic [7:0]                 status;
      logic [`DSP_DEPTH-1:0][7:0] mem;
      logic [`DSP_PW-1:0]         wp;
      logic [`DSP_PW-1:0]         rp;
      logic [`DSP_PW:0]           cnt;
      logic                       overrun;
      logic                       dseen;
      dsp_sh_t                    sh;
      logic [7:0]                 bsh;
      logic [2:0]                 bits;
      logic [7:0]                 bt;
      logic                       mod_bit;
      logic                       rx_data;
      logic                       rx_clk;
   } dsp_core_t;

endpackage

// [dsp_core.sv]
// Dual select serial port with its byte buffer and modem shift register.
// Assumes a host master in clock mode 0,0 on sck_i and a demodulator and
// modulator on clk_i; the pad merges sdo_o and sdo_oe_o into the pin.
`timescale 1ns/1ps

module dsp_core (
   // System clock and reset.
   input  wire logic clk_i,
   input  wire logic reset_i,
   // Serial link from the host.
   input  wire logic sck_i,
   input  wire logic config_select_n_i,
   input  wire logic buffer_select_n_i,
   input  wire logic sdi_i,
   output logic      sdo_o,
   output logic      sdo_oe_o,
   // Modem side.
   input  wire logic demod_bit_i,
   output logic      mod_bit_o,
   output logic      rx_data_o,
   output logic      rx_clock_o
);

   dsp_pkg::dsp_frame_t f;
   dsp_pkg::dsp_frame_t fn;
   dsp_pkg::dsp_store_t s;
   dsp_pkg::dsp_store_t sn;
   dsp_pkg::dsp_out_t   o;
   dsp_pkg::dsp_out_t   on;
   dsp_pkg::dsp_core_t  c;
   dsp_pkg::dsp_core_t  cn;

   logic       idle;
   logic       sel_cfg;
   logic [7:0] byte_in;
   logic [7:0] reply;
   logic [7:0] head;
   logic       rx_mode;
   logic       tx_mode;
   logic       buf_on;
   logic       bs_on;
   logic       empty;
   logic       full;
   logic       cfg_rise;
   logic       dat_rise;
   logic       dbyte_ev;
   logic       spi_push;
   logic       spi_pop;
   logic       tick;
   logic       rbit;
   logic       sh_pop;
   logic       sh_push;
   logic [7:0] sh_byte;
   logic       push;
   logic       pop;
   logic [7:0] pdata;

   // Mode decode from the committed registers; these only change while the
   // configuration select is high, so the link side may read them directly.
   assign rx_mode = c.regs[`DSP_R_GEN][`DSP_ST_HI:`DSP_ST_LO] == `DSP_ST_RX;
   assign tx_mode = c.regs[`DSP_R_GEN][`DSP_ST_HI:`DSP_ST_LO] == `DSP_ST_TX;
   assign buf_on  = c.regs[`DSP_R_DMOD][`DSP_MD_HI:`DSP_MD_LO] != `DSP_MD_CONT;
   assign bs_on   = c.regs[`DSP_R_DMOD][`DSP_BS_BIT];
   assign empty   = c.cnt == '0;
   assign full    = c.cnt[`DSP_PW];
   assign head    = c.mem[c.rp];

   // Select decode straight from the pins: configuration wins over data.
   assign idle     = config_select_n_i & buffer_select_n_i;
   assign sel_cfg  = ~config_select_n_i;
   assign sdo_oe_o = sel_cfg | (~buffer_select_n_i & buf_on);
   assign byte_in  = {f.sh, sdi_i};

   // Byte returned to the host: a register, the status, or the buffer head.
   // A read returns the committed value, never one staged in this frame.
   always_comb begin
      if (!sel_cfg) begin
         reply = head;
      end else if (f.addr == `DSP_R_STAT) begin
         reply = c.status;
      end else begin
         reply = c.regs[f.addr];
      end
   end

   // Link framing: shift on the rising edge, split configuration bytes into
   // address and value, stage writes and hand data bytes to the core.
   always_comb begin
      fn     = f;
      sn     = s;
      fn.sh  = byte_in[6:0];
      fn.cnt = f.cnt + 3'h1;
      if (f.cnt == `DSP_BYTE_END) begin
         if (sel_cfg) begin
            fn.val_ph = ~f.val_ph;
            if (!f.val_ph) begin
               fn.rw   = byte_in[`DSP_A_RW];
               fn.addr = byte_in[`DSP_A_HI:`DSP_A_LO];
            end else if (!f.rw) begin
               sn.stage[f.addr] = byte_in;
               if (s.tog[f.addr] == c.ack[f.addr]) begin
                  sn.tog[f.addr] = ~s.tog[f.addr];
               end
            end
         end else if (buf_on) begin
            sn.dbyte = byte_in;
            sn.dtog  = ~s.dtog;
         end
      end
   end

   // Framing restarts at every frame because the selects clear it at once;
   // the serial clock stands still between frames, so nothing waits on it.
   always_ff @(posedge sck_i or posedge idle) begin
      if (idle) begin
         f <= '0;
      end else begin
         f <= fn;
      end
   end

   // Staged data survives frames and is only cleared by the system reset.
   always_ff @(posedge sck_i or posedge reset_i) begin
      if (reset_i) begin
         s <= '0;
      end else begin
         s <= sn;
      end
   end

   // Output shifter: load the next byte at each byte boundary, else shift.
   always_comb begin
      on.started = 1'b1;
      if (f.cnt == 3'h0) begin
         on.tx = reply;
      end else if (o.started) begin
         on.tx = {o.tx[6:0], 1'b0};
      end else begin
         on.tx = {reply[6:0], 1'b0};
      end
   end

   always_ff @(negedge sck_i or posedge idle) begin
      if (idle) begin
         o <= '0;
      end else begin
         o <= on;
      end
   end

   // The first bit of a frame must be valid before any clock edge, so it is
   // taken from the reply until the first falling edge has loaded the shifter.
   assign sdo_o = o.started ? o.tx[7] : reply[7];

   // Events from the link after two synchroniser flip-flops.
   assign cfg_rise = c.cfg_q[1] & ~c.cfg_q[2];
   assign dat_rise = c.dat_q[1] & ~c.dat_q[2] & c.cfg_q[1];
   assign dbyte_ev = c.dtog_q[1] ^ c.dtog_q[2];
   assign spi_push = dat_rise & buf_on & ~rx_mode & (c.dseen != c.dtog_q[1]);
   assign spi_pop  = dbyte_ev & buf_on & rx_mode;
   assign tick     = c.bt == c.regs[`DSP_R_RATE];

   // Bit synchronizer: a three sample majority removes single-cycle glitches.
   assign rbit = bs_on ? ((c.maj[0] & c.maj[1]) | (c.maj[0] & c.maj[2]) |
                          (c.maj[1] & c.maj[2])) : c.dm_q[1];

   // Buffer ports: the host fills it outside receive, the shifter inside.
   assign push  = spi_push | sh_push;
   assign pop   = spi_pop | sh_pop;
   assign pdata = spi_push ? s.dbyte : sh_byte;

   // Core next state: synchronisers, commit, buffer, shifter and outputs.
   always_comb begin
      cn        = c;
      sh_pop    = 1'b0;
      sh_push   = 1'b0;
      sh_byte   = {c.bsh[6:0], rbit};
      cn.cfg_q  = {c.cfg_q[1:0], config_select_n_i};
      cn.dat_q  = {c.dat_q[1:0], buffer_select_n_i};
      cn.dtog_q = {c.dtog_q[1:0], s.dtog};
      cn.dm_q   = {c.dm_q[0], demod_bit_i};
      cn.maj    = {c.maj[1:0], c.dm_q[1]};
      cn.bt     = tick ? 8'h00 : c.bt + 8'h01;

      // The staging area is quiet while the select is high, so it is safe to
      // copy here; every register written in the burst commits its last value in the same cycle.
      if (cfg_rise) begin
         for (int i = 0; i < `DSP_NREG; i++) begin
            if (s.tog[i] != c.ack[i]) begin
               cn.regs[i] = s.stage[i];
               cn.ack[i]  = s.tog[i];
            end
         end
      end
      if (dat_rise) begin
         cn.dseen = c.dtog_q[1];
      end

      // Status is frozen while the host may be reading it.
      if (c.cfg_q[1]) begin
         cn.status = {c.regs[`DSP_R_GEN][`DSP_ST_HI:`DSP_ST_LO], empty, full,
                      c.overrun, buf_on, bs_on};
      end

      // Modem shifter between the buffer and the modem.
      case (c.sh)
         dsp_pkg::SH_IDLE: begin
            cn.bits = 3'h0;
            if (tx_mode && buf_on && !empty) begin
               sh_pop = 1'b1;
               cn.bsh = head;
               cn.sh  = dsp_pkg::SH_SEND;
            end else if (rx_mode && buf_on) begin
               cn.sh = dsp_pkg::SH_RECV;
            end
         end
         dsp_pkg::SH_SEND: begin
            if (!tx_mode || !buf_on) begin
               cn.sh = dsp_pkg::SH_IDLE;
            end else if (tick) begin
               cn.mod_bit = c.bsh[7];
               cn.bsh     = {c.bsh[6:0], 1'b0};
               cn.bits    = c.bits + 3'h1;
               if (c.bits == `DSP_BYTE_END) begin
                  cn.sh = dsp_pkg::SH_IDLE;
               end
            end
         end
         dsp_pkg::SH_RECV: begin
            if (!rx_mode || !buf_on) begin
               cn.sh = dsp_pkg::SH_IDLE;
            end else if (tick) begin
               cn.bsh  = sh_byte;
               cn.bits = c.bits + 3'h1;
               sh_push = c.bits == `DSP_BYTE_END;
            end
         end
         default: begin
            cn.sh = dsp_pkg::SH_IDLE;
         end
      endcase

      // Buffer: a full buffer drops the byte and flags an overrun; the flag
      // clears outside receive, but a new overrun in that cycle still sets it.
      if (!rx_mode) begin
         cn.overrun = 1'b0;
      end
      if (push && full) begin
         cn.overrun = 1'b1;
      end
      if (push && !full) begin
         cn.mem[c.wp] = pdata;
         cn.wp        = c.wp + 1'b1;
      end
      if (pop && !empty) begin
         cn.rp = c.rp + 1'b1;
      end
      cn.cnt = c.cnt + {{`DSP_PW{1'b0}}, push & ~full} - {{`DSP_PW{1'b0}}, pop & ~empty};

      // Continuous receive: recovered clock and data leave on their own pins.
      cn.rx_data = (rx_mode && !buf_on) ? rbit : 1'b0;
      cn.rx_clk  = (rx_mode && !buf_on) ? (c.bt <= {1'b0, c.regs[`DSP_R_RATE][7:1]}) : 1'b0;

      // Programmed values only return to defaults on reset, not in sleep.
      if (reset_i) begin
         cn        = '0;
         cn.cfg_q  = `DSP_SYNC_IDLE;
         cn.dat_q  = `DSP_SYNC_IDLE;
         for (int i = 0; i < `DSP_NREG; i++) begin
            cn.regs[i] = `DSP_RST;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      c <= cn;
   end

   assign mod_bit_o  = c.mod_bit;
   assign rx_data_o  = c.rx_data;
   assign rx_clock_o = c.rx_clk;

   // A register only changes in the cycle after a configuration release.
   property p_commit;
      @(posedge clk_i) disable iff (reset_i)
      (c.regs != $past(c.regs)) |-> $past(cfg_rise);
   endproperty
   a_commit: assert property (p_commit) else $error("register changed without release");

   // A data write adds exactly one byte when the shifter is not draining.
   property p_push;
      @(posedge clk_i) disable iff (reset_i)
      (spi_push && !full && !sh_pop && !spi_pop) |=> (c.cnt == $past(c.cnt) + 7'h01);
   endproperty
   a_push: assert property (p_push) else $error("buffer write not pushed");

   // The output is released while neither port is selected.
   property p_hiz;
      @(posedge clk_i) disable iff (reset_i)
      (config_select_n_i && buffer_select_n_i) |-> !sdo_oe_o;
   endproperty
   a_hiz: assert property (p_hiz) else $error("output driven while idle");

   // The transmit shifter emits the top bit and shifts a zero in below.
   property p_msb;
      @(posedge clk_i) disable iff (reset_i)
      (c.sh == dsp_pkg::SH_SEND && tick && tx_mode && buf_on) |=>
      (c.mod_bit == $past(c.bsh[7])) && (c.bsh[0] == 1'b0);
   endproperty
   a_msb: assert property (p_msb) else $error("transmit bit order wrong");

   // A completed received byte lands at the write pointer.
   property p_rxbyte;
      @(posedge clk_i) disable iff (reset_i)
      (sh_push && !full) |=> (c.mem[$past(c.wp)] == $past(sh_byte));
   endproperty
   a_rxbyte: assert property (p_rxbyte) else $error("received byte lost");

   // In continuous mode a data select release leaves the buffer untouched.
   property p_cont;
      @(posedge clk_i) disable iff (reset_i)
      (!buf_on && dat_rise) |=> (c.cnt == $past(c.cnt)) && (c.wp == $past(c.wp));
   endproperty
   a_cont: assert property (p_cont) else $error("buffer used in continuous mode");

   // Registers hold their defaults when reset is released.
   property p_defaults;
      @(posedge clk_i)
      $fell(reset_i) |-> (c.regs == {`DSP_NREG{`DSP_RST}});
   endproperty
   a_defaults: assert property (p_defaults) else $error("defaults not loaded");

   // Configuration bytes alternate between address and value.
   property p_alt;
      @(posedge sck_i) disable iff (idle)
      (sel_cfg && f.cnt == `DSP_BYTE_END) |=> (f.val_ph != $past(f.val_ph));
   endproperty
   a_alt: assert property (p_alt) else $error("address and value out of step");

endmodule

// [dsp_host_model.sv]
// Behavioural host master for the dual select serial port, clock mode 0,0.
// Assumes the bench calls xfer one frame at a time and watches got_t_o.
`timescale 1ns/1ps

module dsp_host_model #(
   parameter int CFG_HALF = 90,
   parameter int DAT_HALF = 510
) (
   // Serial link toward the device.
   output logic       sck_o,
   output logic       config_select_n_o,
   output logic       buffer_select_n_o,
   output logic       sdi_o,
   input  wire logic  sdo_i,
   // Reply bytes handed to the bench.
   output logic [7:0] got_o,
   output logic       got_t_o
);
   // Serial clock stands low outside frames and both selects idle high.
   initial begin
      sck_o = 1'b0;
      config_select_n_o = 1'b1;
      buffer_select_n_o = 1'b1;
      sdi_o = 1'b0;
      got_o = 8'h00;
      got_t_o = 1'b0;
   end

   // One frame of whole bytes; replies flagged in keep are published to the bench.
   task automatic xfer(input logic [1:0] sel_n, input logic [7:0] tx[$], input logic [15:0] keep);
      int         half;
      logic [7:0] rx;
      half = sel_n[1] ? DAT_HALF : CFG_HALF;
      {config_select_n_o, buffer_select_n_o} = sel_n;
      foreach (tx[i]) begin
         for (int b = 7; b >= 0; b--) begin
            sdi_o = tx[i][b];
            #(half);
            rx[b] = sdo_i;
            sck_o = 1'b1;
            #(half);
            sck_o = 1'b0;
         end
         if (keep[i]) begin
            got_o = rx;
            got_t_o = ~got_t_o;
         end
      end
      #(half);
      // Whole bytes only, and both selects rise together after the last byte of the frame.
      config_select_n_o = 1'b1;
      buffer_select_n_o = 1'b1;
      // A released line must not keep showing its last value.
      sdi_o = ~sdi_o;
      #300;
   endtask
endmodule

// [tb_top.sv]
// Self-checking bench of the dual select serial port with a host model.
// Assumes dsp_core and dsp_host_model are compiled before it.
`timescale 1ns/1ps

module tb_top;
   logic       clk_i;
   logic       reset_i;
   logic       sck, cfg_n, buf_n, sdi, sdo, sdo_oe, sdo_pin;
   logic       demod_bit_i, mod_bit_o, rx_data_o, rx_clock_o;
   logic [7:0] got, tx_b, txbits;
   logic       got_t;
   logic [7:0] exp_q[$];
   logic [7:0] exp_tx[$];
   int         err_total, n_tests;
   int         seed;
   logic [7:0] rv, n_hi;
   localparam int BIT_P = 8;

   // Don't-care bytes and free register values come from the seeded generator,
   // so that a stuck or ignored input bit shows up as a wrong reply.
   function automatic logic [7:0] rnd();
      return 8'($random(seed));
   endfunction

   // System clock of 50 ns.
   initial clk_i = 1'b0;
   always #25 clk_i = ~clk_i;

   // The pad keeps the last driven level while the output is released.
   always @* if (sdo_oe) sdo_pin = sdo;

   dsp_core dsp_core_i (
      .clk_i             (clk_i),
      .reset_i           (reset_i),
      .sck_i             (sck),
      .config_select_n_i (cfg_n),
      .buffer_select_n_i (buf_n),
      .sdi_i             (sdi),
      .sdo_o             (sdo),
      .sdo_oe_o          (sdo_oe),
      .demod_bit_i       (demod_bit_i),
      .mod_bit_o         (mod_bit_o),
      .rx_data_o         (rx_data_o),
      .rx_clock_o        (rx_clock_o)
   );

   dsp_host_model dsp_host_model_i (
      .sck_o             (sck),
      .config_select_n_o (cfg_n),
      .buffer_select_n_o (buf_n),
      .sdi_o             (sdi),
      .sdo_i             (sdo_pin),
      .got_o             (got),
      .got_t_o           (got_t)
   );

   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Each reply byte is matched against the oldest note. The settling delay
   // keeps the byte and its flag from racing through the ports, and the
   // initial level of the flag is not a reply.
   always @(got_t) begin
      if ($time > 0) begin
         #1;
         if (exp_q.size() == 0) begin
            check("reply_unexpected", got, 8'hXX);
         end else begin
            check("reply_byte", got, exp_q.pop_front());
         end
      end
   end

   // The modulator byte starts with a rising MSB; bits are sampled mid-period.
   always @(posedge clk_i) begin
      if (!reset_i && exp_tx.size() > 0 && mod_bit_o === 1'b1) begin
         repeat (3) @(posedge clk_i);
         for (int b = 7; b >= 0; b--) begin
            txbits[b] = mod_bit_o;
            if (b > 0) repeat (BIT_P) @(posedge clk_i);
         end
         check("modulator_byte", txbits, exp_tx.pop_front());
      end
   end

   // A hang is cut short well after the expected run of about 2100 cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      summarize();
   end

   // Main sequence.
   initial begin
      err_total = 0;
      n_tests = 0;
      seed = 32'h9a9a0074;
      reset_i = 1'b1;
      demod_bit_i = 1'b0;
      repeat (12) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (3) @(negedge clk_i);
      // Defaults and status after reset, read as one chained frame.
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h10);
      fork
         dsp_host_model_i.xfer(2'b01, '{8'h42, rnd(), 8'h46, rnd(), 8'h7E, rnd()}, 16'h002A);
         begin #500; check("oe_config", {7'h00, sdo_oe}, 8'h01); end
      join
      check("oe_idle", {7'h00, sdo_oe}, 8'h00);
      // Continuous mode: the data port neither drives nor pushes.
      fork
         dsp_host_model_i.xfer(2'b10, '{rnd()}, 16'h0000);
         begin #2000; check("oe_continuous", {7'h00, sdo_oe}, 8'h00); end
      join
      exp_q.push_back(8'h10);
      dsp_host_model_i.xfer(2'b01, '{8'h7E, rnd()}, 16'h0002);
      // Both selects low pick the configuration port; the burst is staged.
      // Register 2 steers nothing, so it takes a random value.
      rv = rnd();
      exp_q.push_back(8'h00);
      dsp_host_model_i.xfer(2'b00, '{8'h06, 8'h07, 8'h02, 8'h04, 8'h04, rv, 8'h46, rnd()},
                            16'h0080);
      exp_q.push_back(8'h07);
      exp_q.push_back(8'h04);
      exp_q.push_back(rv);
      exp_q.push_back(8'h12);
      dsp_host_model_i.xfer(2'b01, '{8'h46, rnd(), 8'h42, rnd(), 8'h44, rnd(), 8'h7E, rnd()},
                            16'h00AA);
      // Push one byte, then transmit it to the modulator.
      tx_b = 8'($random(seed)) | 8'h80;
      dsp_host_model_i.xfer(2'b10, '{tx_b}, 16'h0000);
      exp_q.push_back(8'h02);
      dsp_host_model_i.xfer(2'b01, '{8'h7E, rnd()}, 16'h0002);
      exp_tx.push_back(tx_b);
      dsp_host_model_i.xfer(2'b01, '{8'h00, 8'h80}, 16'h0000);
      for (int k = 0; k < 400 && exp_tx.size() > 0; k++) @(posedge clk_i);
      check("tx_pending", 8'(exp_tx.size()), 8'h00);
      exp_q.push_back(8'h92);
      dsp_host_model_i.xfer(2'b01, '{8'h7E, rnd()}, 16'h0002);
      // Receive a steady one level and pop two bytes in one frame.
      @(negedge clk_i);
      demod_bit_i = 1'b1;
      dsp_host_model_i.xfer(2'b01, '{8'h00, 8'h60}, 16'h0000);
      repeat (200) @(negedge clk_i);
      exp_q.push_back(8'hFF);
      exp_q.push_back(8'hFF);
      dsp_host_model_i.xfer(2'b10, '{rnd(), rnd()}, 16'h0003);
      check("rx_clock_buffered", {7'h00, rx_clock_o}, 8'h00);
      check("rx_data_buffered", {7'h00, rx_data_o}, 8'h00);
      // Continuous receive with the bit synchronizer: the steady one level
      // leaves on the data pin and the clock is high for half of each bit.
      dsp_host_model_i.xfer(2'b01, '{8'h02, 8'h02}, 16'h0000);
      repeat (2) @(negedge clk_i);
      check("rx_data_continuous", {7'h00, rx_data_o}, 8'h01);
      n_hi = 8'h00;
      repeat (BIT_P) begin
         @(negedge clk_i);
         n_hi = n_hi + {7'h00, rx_clock_o};
      end
      check("rx_clock_duty", n_hi, 8'h04);
      // A second reset restores the defaults.
      @(negedge clk_i);
      reset_i = 1'b1;
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (3) @(negedge clk_i);
      exp_q.push_back(8'h00);
      dsp_host_model_i.xfer(2'b01, '{8'h46, rnd()}, 16'h0002);
      check("notes_left", 8'(exp_q.size()), 8'h00);
      summarize();
   end
endmodule
